/* design/mcp_ctrl.sv */
// Main clock path control: registers, channel power, source, calibration.
//
// Functional notes
// - Path enable 0 powers down path and buffer, ignoring other fields.
// - Path on: buffer enable 0 powers buffer down, else level 0..6.
// - Each output has its own delay code, about 0.9 ps steps.
// - Source select: 0 bypass, 1 divider, 2 multiplier, shared by all.
// - Divide ratio is code plus one; code 0 reserved; odd duty shorter.
// - Multiplier factor is two to eight from the multiply field.
// - State-machine clock is input over prescale times divide, below 30 MHz.
// - Reset sets the state-machine clock enable to one.
// - Writing register zero with input clock present starts calibration.
// - First calibration or one after source change takes about 5 ms.
// - Lock state readable in status and on the status pin.
// - Format 0 is LVDS, 2 is CML; CML ignores the common-mode code.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mcp_map.svh"
module mcp_ctrl #(
  parameter int NUM_CH = 4,
  parameter int CAL_LONG_CYC = `MCP_CAL_LONG_CYC,
  parameter int CAL_SHORT_CYC = `MCP_CAL_SHORT_CYC
) (
  input wire logic mclk, // System clock, 100 MHz.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic [3:0] reg_addr, // Register address.
  input wire logic [15:0] reg_wdata, // Write data.
  input wire logic reg_write, // Write strobe.
  input wire logic reg_read, // Read strobe.
  output logic [15:0] reg_rdata, // Read data, cycle after the strobe.
  input wire logic input_clock_present, // Input clock detected.
  input wire logic loop_locked, // Raw multiplier loop lock.
  output logic [NUM_CH-1:0] path_power, // Channel path powered.
  output logic [NUM_CH-1:0] buffer_power, // Output buffer powered.
  output logic [3*NUM_CH-1:0] buffer_level, // Buffer level per channel.
  output logic [6*NUM_CH-1:0] output_delay, // Delay code per channel.
  output logic [1:0] main_source, // Active source select.
  output logic [3:0] divide_ratio, // Divider ratio 2..8.
  output logic [3:0] divide_high, // High cycles of divided clock.
  output logic divider_hold, // Divider held in reset.
  output logic divider_resync, // Pulse when divider reset released.
  output logic [3:0] mult_factor, // Multiplier factor 2..8.
  output logic sm_clock_tick, // State-machine clock enable pulse.
  output logic calibrating, // Multiplier calibration running.
  output logic status_output_pin, // Lock indicator pin.
  output logic logic_clock_cml, // Logic clock in CML format.
  output logic [2:0] logic_clock_common_mode, // Common mode in use.
  output logic [2:0] logic_clock_swing, // Swing code.
  output logic irq // Level interrupt.
);
  localparam int CAL_W = $clog2(CAL_LONG_CYC + 1);

  initial begin
    if (NUM_CH != 4 || CAL_SHORT_CYC < 1 || CAL_LONG_CYC < CAL_SHORT_CYC) begin
      $error("mcp_ctrl parameters out of range");
    end
  end

  function automatic logic [2:0] clamp_level(input logic [2:0] code);
    clamp_level = (code > `MCP_PWR_MAX) ? `MCP_PWR_MAX : code;
  endfunction

  function automatic logic mult_ok(input logic [3:0] f);
    mult_ok = (f >= `MCP_MULT_MIN) && (f <= `MCP_MULT_MAX);
  endfunction

  function automatic logic div_hold_fall(input logic held, input logic now);
    div_hold_fall = held && !now;
  endfunction

  // Software-visible configuration.
  logic [15:0] chan;
  logic [15:0] power;
  logic [6*NUM_CH-1:0] delay;
  logic [1:0] src;
  logic [3:0] mult;
  logic [2:0] div_code;
  logic div_rst;
  logic sm_en;
  logic [1:0] sm_pre;
  logic [7:0] sm_div;
  logic [1:0] fmt;
  logic [2:0] vcm;
  logic [2:0] swing;
  logic [2:0] irq_mask;
  logic [15:0] next_chan;
  logic [15:0] next_power;
  logic [6*NUM_CH-1:0] next_delay;
  logic [1:0] next_src;
  logic [3:0] next_mult;
  logic [2:0] next_div_code;
  logic next_div_rst;
  logic next_sm_en;
  logic [1:0] next_sm_pre;
  logic [7:0] next_sm_div;
  logic [1:0] next_fmt;
  logic [2:0] next_vcm;
  logic [2:0] next_swing;
  logic [2:0] next_irq_mask;
  logic wr_zero;
  logic cal_start;

  assign wr_zero = reg_write && (reg_addr == `MCP_OFS_ZERO);
  assign cal_start = wr_zero && input_clock_present;

  always_comb begin
    next_chan = chan;
    next_power = power;
    next_delay = delay;
    next_src = src;
    next_mult = mult;
    next_div_code = div_code;
    next_div_rst = div_rst;
    next_sm_en = sm_en;
    next_sm_pre = sm_pre;
    next_sm_div = sm_div;
    next_fmt = fmt;
    next_vcm = vcm;
    next_swing = swing;
    next_irq_mask = irq_mask;
    if (reg_write) begin
      case (reg_addr)
        `MCP_OFS_ZERO: begin
          // Reserved source code 3 and out-of-range factors are ignored.
          if (reg_wdata[`MCP_ZERO_SRC_LSB +: 2] != 2'h3) begin
            next_src = reg_wdata[`MCP_ZERO_SRC_LSB +: 2];
          end
          if (mult_ok(reg_wdata[`MCP_ZERO_MULT_LSB +: 4])) begin
            next_mult = reg_wdata[`MCP_ZERO_MULT_LSB +: 4];
          end
        end
        `MCP_OFS_CHAN: next_chan = {8'h00, reg_wdata[7:0]};
        `MCP_OFS_POWER: next_power = reg_wdata;
        `MCP_OFS_DELAY_LO: begin
          next_delay[5:0] = reg_wdata[5:0];
          next_delay[11:6] = reg_wdata[13:8];
        end
        `MCP_OFS_DELAY_HI: begin
          next_delay[17:12] = reg_wdata[5:0];
          next_delay[23:18] = reg_wdata[13:8];
        end
        `MCP_OFS_DIV: begin
          if (reg_wdata[2:0] != 3'h0) begin
            next_div_code = reg_wdata[2:0];
          end
          next_div_rst = reg_wdata[`MCP_DIV_RST_BIT];
        end
        `MCP_OFS_SMCLK: begin
          next_sm_en = reg_wdata[0];
          next_sm_pre = reg_wdata[`MCP_SM_PRE_LSB +: 2];
          next_sm_div = reg_wdata[`MCP_SM_DIV_LSB +: 8];
        end
        `MCP_OFS_LCLK: begin
          next_fmt = reg_wdata[1:0];
          next_vcm = reg_wdata[`MCP_LCLK_VCM_LSB +: 3];
          next_swing = reg_wdata[`MCP_LCLK_SWING_LSB +: 3];
        end
        `MCP_OFS_IRQ_MASK: next_irq_mask = reg_wdata[2:0];
        default: next_chan = chan;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      chan <= `MCP_RST_CHAN;
      power <= `MCP_RST_POWER;
      delay <= {NUM_CH{`MCP_RST_DELAY}};
      src <= mcp_pkg::MCP_SRC_BYPASS;
      mult <= `MCP_RST_MULT;
      div_code <= `MCP_RST_DIV_CODE;
      div_rst <= 1'b0;
      sm_en <= 1'b1;
      sm_pre <= 2'h0;
      sm_div <= `MCP_RST_SM_DIV;
      fmt <= 2'h0;
      vcm <= `MCP_RST_LCLK_VCM;
      swing <= `MCP_RST_LCLK_SWING;
      irq_mask <= 3'h0;
    end else begin
      chan <= next_chan;
      power <= next_power;
      delay <= next_delay;
      src <= next_src;
      mult <= next_mult;
      div_code <= next_div_code;
      div_rst <= next_div_rst;
      sm_en <= next_sm_en;
      sm_pre <= next_sm_pre;
      sm_div <= next_sm_div;
      fmt <= next_fmt;
      vcm <= next_vcm;
      swing <= next_swing;
      irq_mask <= next_irq_mask;
    end
  end

  // State-machine clock rate from prescale and divide.
  logic sm_tick;
  mcp_sm_divider #(.CNT_W(10)) u_sm_div (
    .mclk(mclk),
    .resetn(resetn),
    .enable(sm_en),
    .prescale_code(sm_pre),
    .divide(sm_div),
    .tick(sm_tick)
  );
  assign sm_clock_tick = sm_tick;

  // Calibration sequencer and lock tracking.
  mcp_pkg::mcp_cal_state_type cal_state;
  mcp_pkg::mcp_cal_state_type next_cal_state;
  logic [CAL_W-1:0] cal_cnt;
  logic [CAL_W-1:0] next_cal_cnt;
  logic first_done;
  logic next_first_done;
  logic [1:0] cal_src;
  logic [1:0] next_cal_src;
  logic lock;
  logic next_lock;
  logic cal_long;

  // Long calibration on first use or a new source.
  assign cal_long = !first_done || (next_src != cal_src);

  always_comb begin
    next_cal_state = cal_state;
    next_cal_cnt = cal_cnt;
    next_first_done = first_done;
    next_cal_src = cal_src;
    next_lock = lock;
    if (cal_start) begin
      next_cal_state = mcp_pkg::MCP_CAL_RUN;
      next_cal_src = next_src;
      next_cal_cnt = cal_long ? CAL_W'(CAL_LONG_CYC) : CAL_W'(CAL_SHORT_CYC);
    end else begin
      case (cal_state)
        mcp_pkg::MCP_CAL_IDLE: next_cal_state = mcp_pkg::MCP_CAL_IDLE;
        mcp_pkg::MCP_CAL_RUN: begin
          // The sequencer stalls without the state-machine clock.
          if (cal_cnt == '0) begin
            next_cal_state = mcp_pkg::MCP_CAL_SETTLE;
          end else if (sm_en) begin
            next_cal_cnt = cal_cnt - CAL_W'(1);
          end
        end
        mcp_pkg::MCP_CAL_SETTLE: begin
          next_cal_state = mcp_pkg::MCP_CAL_IDLE;
          next_first_done = 1'b1;
        end
        default: next_cal_state = mcp_pkg::MCP_CAL_IDLE;
      endcase
    end
    // Unlocked while calibrating; lock sampled on state ticks.
    if (next_cal_state != mcp_pkg::MCP_CAL_IDLE || !sm_en) begin
      next_lock = 1'b0;
    end else if (sm_tick) begin
      next_lock = loop_locked && next_first_done &&
                  (src == mcp_pkg::MCP_SRC_MULT);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cal_state <= mcp_pkg::MCP_CAL_IDLE;
      cal_cnt <= '0;
      first_done <= 1'b0;
      cal_src <= mcp_pkg::MCP_SRC_BYPASS;
      lock <= 1'b0;
    end else begin
      cal_state <= next_cal_state;
      cal_cnt <= next_cal_cnt;
      first_done <= next_first_done;
      cal_src <= next_cal_src;
      lock <= next_lock;
    end
  end

  // Interrupt status: sticky, cleared by reading; a new event wins.
  logic [2:0] irq_stat;
  logic [2:0] next_irq_stat;
  logic [2:0] events;
  logic rd_stat;

  assign rd_stat = reg_read && (reg_addr == `MCP_OFS_IRQ_STAT);
  always_comb begin
    events = 3'h0;
    events[`MCP_IRQ_CAL_DONE] = cal_state == mcp_pkg::MCP_CAL_SETTLE &&
                                !cal_start;
    events[`MCP_IRQ_LOCK_GAIN] = next_lock && !lock;
    events[`MCP_IRQ_LOCK_LOSS] = !next_lock && lock;
    next_irq_stat = (rd_stat ? 3'h0 : irq_stat) | events;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // Output stage and read data, all registered.
  logic [15:0] next_rdata;
  logic [NUM_CH-1:0] next_path;
  logic [NUM_CH-1:0] next_buf;
  logic [3*NUM_CH-1:0] next_level;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
      assign next_path[ch] = chan[ch];
      // Buffer level only with path and buffer enabled.
      assign next_buf[ch] = chan[ch] && chan[`MCP_CHAN_BUF_LSB + ch];
      assign next_level[3*ch +: 3] = next_buf[ch] ?
                                     clamp_level(power[4*ch +: 3]) : 3'h0;
    end
  endgenerate

  always_comb begin
    next_rdata = 16'h0000;
    if (reg_read) begin
      case (reg_addr)
        `MCP_OFS_ZERO: next_rdata = {8'h00, mult, 2'h0, src};
        `MCP_OFS_CHAN: next_rdata = chan;
        `MCP_OFS_POWER: next_rdata = power;
        `MCP_OFS_DELAY_LO: next_rdata = {2'h0, delay[11:6], 2'h0, delay[5:0]};
        `MCP_OFS_DELAY_HI:
          next_rdata = {2'h0, delay[23:18], 2'h0, delay[17:12]};
        `MCP_OFS_DIV: next_rdata = {11'h000, div_rst, 1'b0, div_code};
        `MCP_OFS_SMCLK: next_rdata = {sm_div, 5'h00, sm_pre, sm_en};
        `MCP_OFS_LCLK: next_rdata = {5'h00, swing, 1'b0, vcm, 2'h0, fmt};
        `MCP_OFS_STATUS: next_rdata = {13'h0000, first_done,
                                       cal_state != mcp_pkg::MCP_CAL_IDLE,
                                       lock};
        `MCP_OFS_IRQ_STAT: next_rdata = {13'h0000, irq_stat};
        `MCP_OFS_IRQ_MASK: next_rdata = {13'h0000, irq_mask};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
      path_power <= '0;
      buffer_power <= '0;
      buffer_level <= '0;
      output_delay <= '0;
      main_source <= mcp_pkg::MCP_SRC_BYPASS;
      divide_ratio <= 4'h2;
      divide_high <= 4'h1;
      divider_hold <= 1'b0;
      divider_resync <= 1'b0;
      mult_factor <= `MCP_RST_MULT;
      calibrating <= 1'b0;
      status_output_pin <= 1'b0;
      logic_clock_cml <= 1'b0;
      logic_clock_common_mode <= 3'h0;
      logic_clock_swing <= 3'h0;
      irq <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      path_power <= next_path;
      buffer_power <= next_buf;
      buffer_level <= next_level;
      output_delay <= delay;
      // One shared source for all outputs.
      main_source <= src;
      // Ratio is code plus one; high time is half, rounded down.
      divide_ratio <= {1'b0, div_code} + 4'h1;
      divide_high <= ({1'b0, div_code} + 4'h1) >> 1;
      divider_hold <= div_rst;
      divider_resync <= div_hold_fall(divider_hold, div_rst);
      mult_factor <= mult;
      calibrating <= cal_state != mcp_pkg::MCP_CAL_IDLE;
      status_output_pin <= lock;
      logic_clock_cml <= fmt == `MCP_FMT_CML;
      logic_clock_common_mode <= (fmt == `MCP_FMT_CML) ? 3'h0 : vcm;
      logic_clock_swing <= swing;
      irq <= |(irq_stat & irq_mask);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_path_off_buffer: assert property (
    !chan[0] |=> !path_power[0] && !buffer_power[0] && buffer_level[2:0] == 0)
    else $error("buffer powered with path off");
  chk_buffer_level: assert property (
    chan[1] && chan[5]
    |=> buffer_level[5:3] == clamp_level($past(power[6:4])))
    else $error("buffer level mismatch");
  chk_delay_update: assert property (
    reg_write && reg_addr == `MCP_OFS_DELAY_LO
    |=> ##1 output_delay[5:0] == $past(reg_wdata[5:0], 2))
    else $error("delay code not applied");
  chk_source_select: assert property (
    wr_zero && reg_wdata[1:0] != 2'h3
    |-> ##2 main_source == $past(reg_wdata[1:0], 2))
    else $error("source select not applied");
  chk_divide_ratio: assert property (
    reg_write && reg_addr == `MCP_OFS_DIV && reg_wdata[2:0] == 3'h4
    |=> ##1 divide_ratio == 4'h5 && divide_high == 4'h2)
    else $error("divide ratio or duty wrong");
  chk_mult_range: assert property (
    mult_factor >= `MCP_MULT_MIN && mult_factor <= `MCP_MULT_MAX)
    else $error("multiplier factor out of range");
  chk_sm_reset_on: assert property (
    $rose(resetn) |-> sm_en)
    else $error("state clock not enabled by reset");
  chk_cal_start: assert property (
    cal_start |=> cal_state == mcp_pkg::MCP_CAL_RUN ##1 calibrating)
    else $error("calibration did not start");
  chk_cal_long: assert property (
    cal_start && !first_done |=> cal_cnt == CAL_W'(CAL_LONG_CYC))
    else $error("first calibration not long");
  chk_lock_pin: assert property (
    status_output_pin == $past(lock))
    else $error("status pin does not follow lock");
  chk_cal_unlocked: assert property (
    cal_state != mcp_pkg::MCP_CAL_IDLE |-> !lock ##1 !status_output_pin)
    else $error("lock shown during calibration");
  chk_cml_vcm: assert property (
    fmt == `MCP_FMT_CML |=> logic_clock_cml && logic_clock_common_mode == 0)
    else $error("common mode used in CML");

  cov_cal_done: cover property (cal_state == mcp_pkg::MCP_CAL_SETTLE);
  cov_lock_gain: cover property (!lock ##1 lock);
  cov_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

/* design/mcp_map.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef MCP_MAP_SVH
`define MCP_MAP_SVH
`define MCP_ADDR_W 4
`define MCP_DATA_W 16
`define MCP_OFS_ZERO 4'h0
`define MCP_OFS_CHAN 4'h1
`define MCP_OFS_POWER 4'h2
`define MCP_OFS_DELAY_LO 4'h3
`define MCP_OFS_DELAY_HI 4'h4
`define MCP_OFS_DIV 4'h5
`define MCP_OFS_SMCLK 4'h6
`define MCP_OFS_LCLK 4'h7
`define MCP_OFS_STATUS 4'h8
`define MCP_OFS_IRQ_STAT 4'h9
`define MCP_OFS_IRQ_MASK 4'hA
`define MCP_ZERO_SRC_LSB 0
`define MCP_ZERO_MULT_LSB 4
`define MCP_CHAN_BUF_LSB 4
`define MCP_DIV_RST_BIT 4
`define MCP_SM_PRE_LSB 1
`define MCP_SM_DIV_LSB 8
`define MCP_LCLK_VCM_LSB 4
`define MCP_LCLK_SWING_LSB 8
`define MCP_RST_CHAN 16'h00FF
`define MCP_RST_POWER 16'h6666
`define MCP_RST_DELAY 6'h00
`define MCP_RST_DIV_CODE 3'h1
`define MCP_RST_MULT 4'h2
`define MCP_RST_SM_DIV 8'h04
`define MCP_RST_LCLK_VCM 3'h3
`define MCP_RST_LCLK_SWING 3'h3
`define MCP_PWR_MAX 3'h6
`define MCP_MULT_MIN 4'h2
`define MCP_MULT_MAX 4'h8
`define MCP_FMT_CML 2'h2
`define MCP_CLK_PERIOD_NS 10
`define MCP_CAL_LONG_NS 5000000
`define MCP_CAL_SHORT_NS 20000
`define MCP_CAL_LONG_CYC (`MCP_CAL_LONG_NS / `MCP_CLK_PERIOD_NS)
`define MCP_CAL_SHORT_CYC (`MCP_CAL_SHORT_NS / `MCP_CLK_PERIOD_NS)
`define MCP_IRQ_CAL_DONE 0
`define MCP_IRQ_LOCK_GAIN 1
`define MCP_IRQ_LOCK_LOSS 2
`endif

/* design/mcp_pkg.sv */
// Types shared by the main clock path control design.
package mcp_pkg;
  typedef enum logic [1:0] {
    MCP_SRC_BYPASS = 2'h0,
    MCP_SRC_DIVIDE = 2'h1,
    MCP_SRC_MULT = 2'h2
  } mcp_source_type;
  typedef enum logic [1:0] {
    MCP_CAL_IDLE = 2'h0,
    MCP_CAL_RUN = 2'h1,
    MCP_CAL_SETTLE = 2'h3
  } mcp_cal_state_type;
endpackage

/* design/mcp_sm_divider.sv */
// State-machine clock enable divider: one tick per prescale times divide.
`timescale 1ns/1ps
`default_nettype none
module mcp_sm_divider #(
  parameter int CNT_W = 10
) (
  input wire logic mclk, // System clock.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic enable, // Runs the divider while high.
  input wire logic [1:0] prescale_code, // 0:1, 1:2, 2 or 3:4.
  input wire logic [7:0] divide, // Divide value, 0 acts as 1.
  output logic tick // One-cycle state-machine clock enable.
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_tick;
  logic [CNT_W-1:0] total;

  initial begin
    if (CNT_W < 10) begin
      $error("mcp_sm_divider needs at least 10 count bits");
    end
  end

  always_comb begin
    total = (divide == 8'h00) ? CNT_W'(1) : CNT_W'(divide);
    case (prescale_code)
      2'h0: total = total;
      2'h1: total = CNT_W'(total << 1);
      default: total = CNT_W'(total << 2);
    endcase
    next_count = count;
    next_tick = 1'b0;
    if (!enable) begin
      next_count = '0;
    end else if (count + CNT_W'(1) >= total) begin
      next_count = '0;
      next_tick = 1'b1;
    end else begin
      next_count = count + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

/* verification/main_clock_path_control_tb_top.sv */
// Self-checking bench for the main clock path control block.
`timescale 1ns/1ps
`default_nettype none
`include "mcp_map.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module main_clock_path_control_tb_top;
  logic mclk = 0, resetn = 0, reg_write = 0, reg_read = 0, clk_ok = 1;
  logic [3:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, rv, d, seed = 16'h0031;
  logic [15:0] mreg [0:10];
  wire logic [15:0] reg_rdata;
  wire logic [3:0] pp, bp, dr, dh, mf;
  wire logic [11:0] bl;
  wire logic [23:0] od;
  wire logic [1:0] ms;
  wire logic hold, rsy, tick, cal, pin, cml, irq, lk;
  wire logic [2:0] cm, sw;
  int error_cnt = 0, checks = 0, n, k, ratio;
  mcp_ctrl #(.CAL_LONG_CYC(50), .CAL_SHORT_CYC(10)) DUT (.mclk(mclk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .input_clock_present(clk_ok), .loop_locked(lk), .path_power(pp),
    .buffer_power(bp), .buffer_level(bl), .output_delay(od),
    .main_source(ms), .divide_ratio(dr), .divide_high(dh),
    .divider_hold(hold), .divider_resync(rsy), .mult_factor(mf),
    .sm_clock_tick(tick), .calibrating(cal), .status_output_pin(pin),
    .logic_clock_cml(cml), .logic_clock_common_mode(cm),
    .logic_clock_swing(sw), .irq(irq));
  mcp_loop_model loop (.mclk(mclk), .calibrating(cal), .loop_locked(lk));
  initial forever #5 mclk = ~mclk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [11:0] exp_lvl();
    logic [11:0] r;
    logic [2:0] p;
    r = 0;
    for (int i = 0; i < 4; i++) begin
      p = mreg[2][4*i+:3];
      if (p == 3'h7) p = `MCP_PWR_MAX;
      if (mreg[1][i] && mreg[1][4+i]) r[3*i+:3] = p;
    end
    return r;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic cal_len(output int len);
    len = 0;
    for (int t = 0; t < 6 && cal !== 1'b1; t++) @(posedge mclk);
    while (cal === 1'b1 && len < 100) begin
      @(posedge mclk);
      len++;
    end
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #300000;
    error_cnt++;
    end_sim();
  end
  initial begin
    mreg[0] = {8'h0, `MCP_RST_MULT, 4'h0};
    mreg[1] = `MCP_RST_CHAN;
    mreg[2] = `MCP_RST_POWER;
    mreg[3] = 0;
    mreg[4] = 0;
    mreg[5] = 16'h0001;
    mreg[6] = {`MCP_RST_SM_DIV, 8'h01};
    mreg[7] = {5'h0, `MCP_RST_LCLK_SWING, 1'b0, `MCP_RST_LCLK_VCM, 4'h0};
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    for (k = 0; k < 8; k++) begin
      if (k == 3 || k == 4) continue;
      rd(k[3:0], d);
      `CHK("reset word", mreg[k], d)
    end
    rd(4'hB, d);
    `CHK("unmapped", 16'h0000, d)
    `CHK("level", exp_lvl(), bl)
    `CHK("ratio", 4'h2, dr)
    // tick spacing of prescale two times divide three
    // the state-machine clock stays enabled for the whole run.
    wr(`MCP_OFS_SMCLK, 16'h0303);
    k = 0;
    do begin
      @(posedge mclk);
      #1 k++;
    end while (tick !== 1'b1 && k < 20);
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (tick !== 1'b1 && n < 40);
    `CHK("tick gap", 6, n)
    wr(`MCP_OFS_IRQ_MASK, 16'h0001);
    mreg[0] = 16'h0082;
    wr(`MCP_OFS_ZERO, 16'h0082);
    cal_len(n);
    `CHK("first cal", 1, n >= 50 && n <= 52)
    settle();
    `CHK("irq", 1'b1, irq)
    rd(`MCP_OFS_IRQ_STAT, d);
    `CHK("cal done", 1'b1, d[0])
    settle();
    `CHK("irq clr", 1'b0, irq)
    wr(`MCP_OFS_ZERO, 16'h0082);
    cal_len(n);
    `CHK("short cal", 1, n >= 10 && n <= 12)
    repeat (30) @(posedge mclk);
    rd(`MCP_OFS_STATUS, d);
    `CHK("locked", 1'b1, d[0])
    `CHK("pin", 1'b1, pin)
    wr(`MCP_OFS_ZERO, 16'h0082);
    rd(`MCP_OFS_STATUS, d);
    `CHK("lock in cal", 2'h2, d[1:0])
    cal_len(n);
    clk_ok <= 1'b0;
    wr(`MCP_OFS_ZERO, 16'h0082);
    settle();
    `CHK("no clock", 1'b0, cal)
    clk_ok <= 1'b1;
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      mreg[1] = seed & 16'h00FF;
      wr(`MCP_OFS_CHAN, mreg[1]);
      seed = lfsr(seed);
      mreg[2] = seed;
      // delay codes are kept at four or more.
      mreg[3] = seed & 16'h3F3F | 16'h0404;
      mreg[4] = ~seed & 16'h3F3F | 16'h0404;
      wr(`MCP_OFS_POWER, mreg[2]);
      wr(`MCP_OFS_DELAY_LO, mreg[3]);
      wr(`MCP_OFS_DELAY_HI, mreg[4]);
      settle();
      `CHK("path", mreg[1][3:0], pp)
      `CHK("buffer", mreg[1][3:0] & mreg[1][7:4], bp)
      `CHK("level", exp_lvl(), bl)
      `CHK("delay", {mreg[4][13:8], mreg[4][5:0], mreg[3][13:8],
        mreg[3][5:0]}, od)
    end
    // source and factor codes with refusals
    for (k = 1; k < 10; k++) begin
      rv = {8'h0, k[3:0], 2'h0, k[1:0]};
      if (k % 4 != 3) mreg[0][1:0] = k[1:0];
      if (k >= 2 && k <= 8) mreg[0][7:4] = k[3:0];
      wr(`MCP_OFS_ZERO, rv);
      settle();
      `CHK("source", mreg[0][1:0], ms)
      `CHK("factor", mreg[0][7:4], mf)
    end
    ratio = 2;
    for (k = 0; k < 8; k++) begin
      if (k != 0) ratio = k + 1;
      wr(`MCP_OFS_DIV, k[15:0]);
      settle();
      `CHK("ratio", ratio[3:0], dr)
      `CHK("high", ratio[4:1], dh)
    end
    // divider reset release gives one resync pulse
    wr(`MCP_OFS_DIV, 16'h0013);
    settle();
    `CHK("hold", 1'b1, hold)
    wr(`MCP_OFS_DIV, 16'h0003);
    n = 0;
    repeat (5) begin
      @(posedge mclk);
      #1 n += rsy;
    end
    `CHK("resync", 1, n)
    // CML ignores the common-mode code, LVDS uses it
    wr(`MCP_OFS_LCLK, 16'h0652);
    settle();
    `CHK("cml", 4'h8, {cml, cm})
    // common-mode code 5 suits swing code 6 in LVDS.
    wr(`MCP_OFS_LCLK, 16'h0650);
    settle();
    `CHK("lvds", 7'h2E, {cml, cm, sw})
    end_sim();
  end
endmodule
`default_nettype wire

/* verification/mcp_loop_model.sv */
// Behavioural model of the multiplier loop beyond the control block.
`timescale 1ns/1ps
`default_nettype none
module mcp_loop_model #(
  parameter int LOCK_DLY = 3
) (
  input wire logic mclk, // System clock.
  input wire logic calibrating, // Calibration running.
  output logic loop_locked // Raw loop lock.
);
  int cnt = 0;
  initial loop_locked = 1'b0;
  // The loop cannot hold lock while its bands are being searched.
  always @(posedge mclk) begin
    if (calibrating) begin
      cnt <= 0;
      loop_locked <= 1'b0;
    end else if (cnt < LOCK_DLY) begin
      cnt <= cnt + 1;
    end else begin
      loop_locked <= 1'b1;
    end
  end
endmodule
`default_nettype wire
